/* File: logic/asp_cfg.svh */
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// ****************************************
// Command byte layout
// ****************************************
`define ASP_CMD_BITS        8
`define ASP_CMD_WEN_BIT     7
`define ASP_CMD_RW_BIT      6
`define ASP_CMD_RS_MSB      5
`define ASP_CMD_RS_LSB      3
`define ASP_RS_WIDTH        3

// ****************************************
// Register selections
// ****************************************
`define ASP_RS_COMMS        3'h0
`define ASP_RS_DATA         3'h3

// ****************************************
// Transfer lengths, minus one
// ****************************************
`define ASP_CNT_WIDTH       5
`define ASP_LAST_CMD        5'h07
`define ASP_LAST_SHORT      5'h07
`define ASP_LAST_LONG       5'h17
`define ASP_DATA_WIDTH      24
`define ASP_SHORT_WIDTH     8

// ****************************************
// Result buffer and reset values
// ****************************************
`define ASP_FIFO_DEPTH      8
`define ASP_SYNC_WIDTH      6
`define ASP_SYNC_RST        6'h2C

// ****************************************
// Timing
// ****************************************
`define ASP_CLK_PERIOD_NS   25
`define ASP_RDY_GAP_NS      100
`define ASP_RDY_GAP_CYC     ((`ASP_RDY_GAP_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_RDY_CNT_W       4
`define ASP_INT_OSC_KHZ     4920

`endif

/* File: logic/asp_pkg.sv */
`include "asp_cfg.svh"

package asp_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {ASP_ST_COMMS, ASP_ST_WRITE, ASP_ST_READ} asp_state_t;
    typedef logic [`ASP_RS_WIDTH-1:0]   asp_rs_t;
    typedef logic [`ASP_CNT_WIDTH-1:0]  asp_cnt_t;
    typedef logic [`ASP_DATA_WIDTH-1:0] asp_word_t;

endpackage

/* File: logic/asp_sync.sv */
module asp_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ****************************************
    // Two flops per bit
    // ****************************************
    genvar i;
    generate
        if (WIDTH < 1)
        begin : g_bad
            $error("asp_sync: WIDTH must be at least 1");
        end
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_ff <= RST_VAL[i];
                    sync_ff <= RST_VAL[i];
                end
                else
                begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign sync_out[i] = sync_ff;
        end
    endgenerate

endmodule

/* File: logic/asp_fifo.sv */
module asp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin : g_bad
            $error("asp_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    // ****************************************
    // Storage and pointers
    // ****************************************
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    wire              push;
    wire              pop;

    assign in_ready  = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) || (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end

endmodule

/* File: logic/asp_serial_port.sv */
`include "asp_cfg.svh"

module asp_serial_port #(
    parameter int DATA_WIDTH = `ASP_DATA_WIDTH,
    parameter int FIFO_DEPTH = `ASP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Serial pins
    input  wire logic                  sclk,
    input  wire logic                  din,
    input  wire logic                  cs_n,
    output logic                       dout_rdy_o,
    output logic                       dout_rdy_oe,
    // Filter synchronisation pin and resets
    input  wire logic                  sync_n,
    output logic                       filter_rst,
    output logic                       filter_ctl_rst,
    output logic                       cal_ctl_rst,
    output logic                       mod_rst,
    // Master clock pin and oscillator
    input  wire logic                  osc_clk,
    input  wire logic                  use_int_osc,
    input  wire logic                  mclk_out_en,
    input  wire logic                  master_clock_io_i,
    output logic                       master_clock_io_o,
    output logic                       master_clock_io_oe,
    output logic                       core_clk_level,
    // Conversion results
    input  wire logic                  conv_valid,
    output logic                       conv_ready,
    input  wire logic [DATA_WIDTH-1:0] conv_data,
    // Register map
    output logic                       reg_wr_valid,
    output logic [`ASP_RS_WIDTH-1:0]   reg_wr_sel,
    output logic [DATA_WIDTH-1:0]      reg_wr_data,
    output logic [`ASP_RS_WIDTH-1:0]   reg_rd_sel,
    input  wire logic [DATA_WIDTH-1:0] reg_rd_data
);

    generate
        if (DATA_WIDTH != `ASP_DATA_WIDTH || FIFO_DEPTH < 2)
        begin : g_bad
            $error("asp_serial_port: DATA_WIDTH must be 24 and FIFO_DEPTH at least 2");
        end
    endgenerate

    // ****************************************
    // Length decode
    // ****************************************
    function automatic asp_pkg::asp_cnt_t last_bit_of(input asp_pkg::asp_rs_t rs);
        last_bit_of = (rs == `ASP_RS_COMMS) ? `ASP_LAST_SHORT : `ASP_LAST_LONG;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [`ASP_SYNC_WIDTH-1:0] pins_s;
    wire                       sclk_s;
    wire                       din_s;
    wire                       cs_n_s;
    wire                       sync_n_s;
    wire                       osc_s;
    wire                       mclk_s;

    asp_sync #(
        .WIDTH   (`ASP_SYNC_WIDTH),
        .RST_VAL (`ASP_SYNC_RST)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({sclk, din, cs_n, sync_n, osc_clk, master_clock_io_i}),
        .sync_out (pins_s)
    );

    assign sclk_s   = pins_s[5];
    assign din_s    = pins_s[4];
    assign cs_n_s   = pins_s[3];
    assign sync_n_s = pins_s[2];
    assign osc_s    = pins_s[1];
    assign mclk_s   = pins_s[0];

    // ****************************************
    // Result buffer
    // ****************************************
    wire                  fifo_out_valid;
    wire [DATA_WIDTH-1:0] fifo_out_data;
    logic                 pop_ff;
    wire                  push_fire;

    asp_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .in_data   (conv_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop_ff),
        .out_data  (fifo_out_data)
    );

    assign push_fire = conv_valid & conv_ready;

    // ****************************************
    // Filter and modulator resets
    // ****************************************
    assign filter_rst     = ~sync_n_s;
    assign filter_ctl_rst = ~sync_n_s;
    assign cal_ctl_rst    = ~sync_n_s;
    assign mod_rst        = ~sync_n_s;

    // ****************************************
    // Master clock pin
    // ****************************************
    assign master_clock_io_oe = use_int_osc & mclk_out_en;
    assign master_clock_io_o  = osc_s;
    assign core_clk_level     = use_int_osc ? osc_s : mclk_s;

    // ****************************************
    // Serial clock edges
    // ****************************************
    logic sclk_d_ff;
    wire  selected;
    wire  sclk_rise;
    wire  sclk_fall;

    assign selected  = ~cs_n_s;
    assign sclk_rise = selected & sclk_s & ~sclk_d_ff;
    assign sclk_fall = selected & ~sclk_s & sclk_d_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sclk_d_ff <= 1'b1;
        else
            sclk_d_ff <= sclk_s;
    end

    // ****************************************
    // Transfer state
    // ****************************************
    asp_pkg::asp_state_t state_ff;
    asp_pkg::asp_state_t nxt_state;
    asp_pkg::asp_cnt_t   cnt_ff;
    asp_pkg::asp_cnt_t   nxt_cnt;
    asp_pkg::asp_rs_t    rs_ff;
    asp_pkg::asp_rs_t    nxt_rs;
    asp_pkg::asp_word_t  rxsh_ff;
    asp_pkg::asp_word_t  txsh_ff;
    logic                load_ff;
    logic                nxt_load;
    logic                wr_valid_ff;
    logic                nxt_wr_valid;
    logic                pin_ff;
    wire  [DATA_WIDTH-1:0] rx_next;
    wire  [`ASP_RS_WIDTH-1:0] cmd_rs;
    wire                 cmd_wen;
    wire                 cmd_read;
    wire                 cnt_done;
    wire  [DATA_WIDTH-1:0] rd_src;
    wire  [DATA_WIDTH-1:0] tx_load;
    wire  [DATA_WIDTH-1:0] wr_word;

    assign rx_next  = {rxsh_ff[DATA_WIDTH-2:0], din_s};
    assign cmd_rs   = rx_next[`ASP_CMD_RS_MSB:`ASP_CMD_RS_LSB];
    assign cmd_wen  = rx_next[`ASP_CMD_WEN_BIT];
    assign cmd_read = rx_next[`ASP_CMD_RW_BIT];
    assign cnt_done = (cnt_ff == '0);

    // Source of a read: head of the result buffer or the chosen register
    assign rd_src  = (rs_ff == `ASP_RS_DATA) ? fifo_out_data : reg_rd_data;
    assign tx_load = (last_bit_of(rs_ff) == `ASP_LAST_SHORT) ?
                     {rd_src[`ASP_SHORT_WIDTH-1:0], {(DATA_WIDTH-`ASP_SHORT_WIDTH){1'b0}}} : rd_src;
    // Short registers take only the last byte shifted in
    assign wr_word = (last_bit_of(rs_ff) == `ASP_LAST_SHORT) ?
                     {{(DATA_WIDTH-`ASP_SHORT_WIDTH){1'b0}}, rx_next[`ASP_SHORT_WIDTH-1:0]} : rx_next;

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_rs       = rs_ff;
        nxt_load     = 1'b0;
        nxt_wr_valid = 1'b0;
        if (!selected)
        begin
            nxt_state = asp_pkg::ASP_ST_COMMS;
            nxt_cnt   = `ASP_LAST_CMD;
        end
        else if (sclk_rise)
        begin
            nxt_cnt = cnt_ff - `ASP_CNT_WIDTH'(1);
            case (state_ff)
                asp_pkg::ASP_ST_COMMS:
                begin
                    if (cnt_done)
                    begin
                        nxt_cnt = `ASP_LAST_CMD;
                        if (!cmd_wen)
                        begin
                            nxt_rs  = cmd_rs;
                            nxt_cnt = last_bit_of(cmd_rs);
                            if (cmd_read)
                            begin
                                nxt_state = asp_pkg::ASP_ST_READ;
                                nxt_load  = 1'b1;
                            end
                            else
                                nxt_state = asp_pkg::ASP_ST_WRITE;
                        end
                    end
                end
                asp_pkg::ASP_ST_WRITE:
                begin
                    if (cnt_done)
                    begin
                        nxt_state    = asp_pkg::ASP_ST_COMMS;
                        nxt_cnt      = `ASP_LAST_CMD;
                        nxt_wr_valid = 1'b1;
                    end
                end
                asp_pkg::ASP_ST_READ:
                begin
                    if (cnt_done)
                    begin
                        nxt_state = asp_pkg::ASP_ST_COMMS;
                        nxt_cnt   = `ASP_LAST_CMD;
                    end
                end
                default:
                begin
                    nxt_state = asp_pkg::ASP_ST_COMMS;
                    nxt_cnt   = `ASP_LAST_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= asp_pkg::ASP_ST_COMMS;
            cnt_ff      <= `ASP_LAST_CMD;
            rs_ff       <= `ASP_RS_COMMS;
            load_ff     <= 1'b0;
            wr_valid_ff <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            rs_ff       <= nxt_rs;
            load_ff     <= nxt_load;
            wr_valid_ff <= nxt_wr_valid;
        end
    end

    // ****************************************
    // Shift registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxsh_ff     <= '0;
            txsh_ff     <= '0;
            reg_wr_data <= '0;
            pop_ff      <= 1'b0;
        end
        else
        begin
            pop_ff <= 1'b0;
            if (sclk_rise && state_ff != asp_pkg::ASP_ST_READ)
                rxsh_ff <= rx_next;
            if (nxt_wr_valid)
                reg_wr_data <= wr_word;
            if (load_ff)
            begin
                txsh_ff <= tx_load;
                pop_ff  <= (rs_ff == `ASP_RS_DATA) & fifo_out_valid;
            end
            else if (sclk_fall && state_ff == asp_pkg::ASP_ST_READ)
                txsh_ff <= {txsh_ff[DATA_WIDTH-2:0], 1'b0};
        end
    end

    assign reg_wr_valid = wr_valid_ff;
    assign reg_wr_sel   = rs_ff;
    assign reg_rd_sel   = rs_ff;

    // ****************************************
    // Data ready tracking
    // ****************************************
    logic                      rdy_n_ff;
    logic                      nxt_rdy_n;
    logic [`ASP_RDY_CNT_W-1:0] gap_ff;
    logic [`ASP_RDY_CNT_W-1:0] nxt_gap;
    wire                       data_read;

    assign data_read = load_ff & (rs_ff == `ASP_RS_DATA);

    always_comb
    begin
        nxt_rdy_n = rdy_n_ff;
        nxt_gap   = gap_ff;
        if (gap_ff != '0)
        begin
            nxt_gap = gap_ff - `ASP_RDY_CNT_W'(1);
            if (gap_ff == `ASP_RDY_CNT_W'(1))
                nxt_rdy_n = 1'b0;
        end
        if (data_read)
        begin
            nxt_rdy_n = 1'b1;
            nxt_gap   = '0;
        end
        if (push_fire)
        begin
            if (!rdy_n_ff || gap_ff != '0)
            begin
                nxt_rdy_n = 1'b1;
                nxt_gap   = `ASP_RDY_CNT_W'(`ASP_RDY_GAP_CYC);
            end
            else
                nxt_rdy_n = 1'b0;
        end
        if (!sync_n_s)
        begin
            nxt_rdy_n = 1'b1;
            nxt_gap   = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_n_ff <= 1'b1;
            gap_ff   <= '0;
        end
        else
        begin
            rdy_n_ff <= nxt_rdy_n;
            gap_ff   <= nxt_gap;
        end
    end

    // ****************************************
    // Shared data and ready pin
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_ff <= 1'b1;
        else if (state_ff == asp_pkg::ASP_ST_READ)
        begin
            if (sclk_fall)
                pin_ff <= txsh_ff[DATA_WIDTH-1];
        end
        else
            pin_ff <= rdy_n_ff;
    end

    assign dout_rdy_o  = pin_ff;
    assign dout_rdy_oe = selected;

endmodule

/* File: tb/asp_checker.sv */
// ****
// Port checker
// ****
module asp_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout_rdy_o,
    input wire logic dout_rdy_oe,
    input wire logic reg_wr_valid,
    // Sync and resets
    input wire logic sync_n,
    input wire logic filter_rst,
    input wire logic filter_ctl_rst,
    input wire logic cal_ctl_rst,
    input wire logic mod_rst,
    // Master clock
    input wire logic osc_clk,
    input wire logic use_int_osc,
    input wire logic mclk_out_en,
    input wire logic master_clock_io_o,
    input wire logic master_clock_io_oe,
    input wire logic core_clk_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire all_rst = filter_rst & filter_ctl_rst & cal_ctl_rst & mod_rst;
    wire any_rst = filter_rst | filter_ctl_rst | cal_ctl_rst | mod_rst;

    AST_RST_ON: assert property ((!sync_n)[*4] |-> all_rst)
        else $error("Resets not held while sync low");
    AST_RST_OFF: assert property (sync_n[*4] |-> !any_rst)
        else $error("Resets held while sync high");
    AST_RDY_SYNC: assert property ((!sync_n && sclk)[*6] |-> !$fell(dout_rdy_o))
        else $error("Ready fell while sync low");
    AST_OE_ON: assert property ((!cs_n)[*4] |-> dout_rdy_oe)
        else $error("Data pin not driven while selected");
    AST_OE_OFF: assert property (cs_n[*4] |-> !dout_rdy_oe)
        else $error("Data pin driven while deselected");
    AST_NO_WR: assert property (cs_n[*8] |-> !reg_wr_valid)
        else $error("Register write while deselected");
    AST_WR_SEL: assert property (reg_wr_valid |-> !$past(cs_n, 4))
        else $error("Register write without select");
    AST_MCLK_OE: assert property (master_clock_io_oe == (use_int_osc && mclk_out_en))
        else $error("Master clock enable wrong");
    AST_MCLK_O: assert property ($stable(osc_clk)[*5] |-> master_clock_io_o == osc_clk)
        else $error("Master clock out not oscillator");
    AST_CORE: assert property (($stable(osc_clk) && use_int_osc)[*5] |-> core_clk_level == osc_clk)
        else $error("Core clock not oscillator");
endmodule

bind asp_serial_port asp_checker asp_checker_i (.ref_clk, .rst_n, .sclk, .cs_n, .dout_rdy_o, .dout_rdy_oe,
    .reg_wr_valid, .sync_n, .filter_rst, .filter_ctl_rst, .cal_ctl_rst, .mod_rst, .osc_clk, .use_int_osc,
    .mclk_out_en, .master_clock_io_o, .master_clock_io_oe, .core_clk_level);

/* File: tb/asp_host.sv */
// ****
// Host serial port model
// ****
module asp_host (
    // Clock
    input  wire logic   ref_clk,
    // Device pins
    input  wire logic   pin,
    output logic        sclk,
    output logic        din,
    output logic        cs_n,
    // Read result
    output logic        rd_done,
    output logic [23:0] rd_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclk    = 1'b1;
        din     = 1'b0;
        cs_n    = 1'b1;
        rd_done = 1'b0;
        rd_word = 24'h00_0000;
    end

    // Sends n bits of w, MSB first
    task automatic xfer(input logic [31:0] w, input int n, input logic sel);
        @(posedge ref_clk);
        cs_n    <= ~sel;
        rd_word <= 24'h00_0000;
        repeat (4) @(posedge ref_clk);
        for (int k = 0; k < n; k++)
        begin
            sclk <= 1'b0;
            din  <= w[31-k];
            repeat (5) @(posedge ref_clk);
            sclk <= 1'b1;
            if (k >= 8)
                rd_word <= {rd_word[22:0], pin};
            repeat ((k == 12) ? 20 : 3) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
        rd_done <= w[30] & sel;
        @(posedge ref_clk);
        rd_done <= 1'b0;
    endtask
endmodule

/* File: tb/tb.sv */
// ****
// Testbench
// ****
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t got %h", $time, a); end end
    logic             ref_clk, rst_n, sync_n, osc_clk, use_int_osc, mclk_out_en, ext_clk, conv_valid, pin_ff;
    logic [23:0]      conv_data, reg_wr_data;
    logic [31:0]      rnd;
    wire logic        sclk, din, cs_n, pin, rd_done, mclk_pin;
    wire logic [23:0] rd_word, reg_rd_data;
    logic             dout_rdy_o, dout_rdy_oe, filter_rst, filter_ctl_rst, cal_ctl_rst, mod_rst;
    logic             master_clock_io_o, master_clock_io_oe, core_clk_level, conv_ready, reg_wr_valid;
    logic [2:0]       reg_wr_sel, reg_rd_sel;
    logic [26:0]      exp_q[$];
    logic [23:0]      fifo_q[$];
    int               mismatches, tests_run, cyc;

    function automatic logic [23:0] rmap(input logic [2:0] s);
        return 24'h5A_A5C3 ^ {8{s}};
    endfunction
    assign pin         = dout_rdy_oe ? dout_rdy_o : ~pin_ff;
    assign mclk_pin    = master_clock_io_oe ? master_clock_io_o : ext_clk;
    assign reg_rd_data = rmap(reg_rd_sel);
    always @(posedge ref_clk) if (dout_rdy_oe === 1'b1) pin_ff <= dout_rdy_o;
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    asp_serial_port asp_serial_port_i (.ref_clk, .rst_n, .sclk, .din, .cs_n, .dout_rdy_o, .dout_rdy_oe, .sync_n,
        .filter_rst, .filter_ctl_rst, .cal_ctl_rst, .mod_rst, .osc_clk, .use_int_osc, .mclk_out_en,
        .master_clock_io_i(mclk_pin), .master_clock_io_o, .master_clock_io_oe, .core_clk_level, .conv_valid,
        .conv_ready, .conv_data, .reg_wr_valid, .reg_wr_sel, .reg_wr_data, .reg_rd_sel, .reg_rd_data);
    asp_host asp_host_i (.ref_clk, .pin, .sclk, .din, .cs_n, .rd_done, .rd_word);

    function automatic void step();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
    endfunction
    function automatic logic [26:0] note();
        return exp_q.size() ? exp_q.pop_front() : 'x;
    endfunction
    task automatic push(input logic [23:0] d);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_data  <= d;
        @(posedge ref_clk);
        if (conv_ready === 1'b1)
            fifo_q.push_back(d);
        conv_valid <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] s);
        logic [23:0] e;
        e = (s == 3'h3) ? fifo_q.pop_front() : rmap(s);
        if (s == 3'h0)
            e = {16'h0000, e[7:0]};
        exp_q.push_back({3'h0, e});
        asp_host_i.xfer({2'b01, s, 3'h0, 24'h00_0000}, (s == 3'h0) ? 16 : 32, 1'b1);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Result monitor
    always @(posedge ref_clk)
    begin
        if (reg_wr_valid === 1'b1) `CHK({reg_wr_sel, reg_wr_data}, note())
        if (rd_done === 1'b1) `CHK({3'h0, rd_word}, note())
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        rnd         = 32'h0000_AF7B;
        rst_n       = 1'b0;
        sync_n      = 1'b1;
        osc_clk     = 1'b0;
        use_int_osc = 1'b0;
        mclk_out_en = 1'b0;
        ext_clk     = 1'b0;
        conv_valid  = 1'b0;
        conv_data   = 24'h00_0000;
        pin_ff      = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 `CHK(dout_rdy_oe, 1'b0)
        asp_host_i.xfer(32'h0812_3456, 32, 1'b0);
        asp_host_i.xfer(32'h8800_0000, 8, 1'b1);
        for (int s = 0; s < 8; s++)
        begin
            step();
            exp_q.push_back({3'(s), (s == 0) ? {16'h0000, rnd[23:16]} : rnd[23:0]});
            asp_host_i.xfer({2'b00, 3'(s), 3'h0, rnd[23:0]}, (s == 0) ? 16 : 32, 1'b1);
        end
        for (int s = 0; s < 8; s++)
            if (s != 3)
                rd(3'(s));
        #1 `CHK(dout_rdy_o, 1'b1)
        step();
        push(rnd[23:0]);
        repeat (4) @(posedge ref_clk);
        #1 `CHK(dout_rdy_o, 1'b0)
        step();
        push(rnd[23:0]);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(dout_rdy_o, 1'b1)
        repeat (6) @(posedge ref_clk);
        #1 `CHK(dout_rdy_o, 1'b0)
        while (conv_ready === 1'b1 && fifo_q.size() < 9)
        begin
            step();
            push(rnd[23:0]);
            #1;
        end
        step();
        push(rnd[23:0]);
        `CHK(fifo_q.size(), 8)
        repeat (6) @(posedge ref_clk);
        #1 `CHK(dout_rdy_o, 1'b0)
        @(posedge ref_clk) sync_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 `CHK(dout_rdy_o, 1'b1)
        `CHK({filter_rst, filter_ctl_rst, cal_ctl_rst, mod_rst}, 4'hF)
        rd(3'h3);
        @(posedge ref_clk) sync_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 `CHK({filter_rst, filter_ctl_rst, cal_ctl_rst, mod_rst}, 4'h0)
        while (fifo_q.size() > 0)
            rd(3'h3);
        #1 `CHK(conv_ready, 1'b1)
        `CHK(dout_rdy_o, 1'b1)
        for (int k = 0; k < 4; k++)
        begin
            step();
            @(posedge ref_clk);
            use_int_osc <= k[0];
            mclk_out_en <= k[1];
            osc_clk     <= rnd[0];
            ext_clk     <= ~rnd[0];
            repeat (6) @(posedge ref_clk);
            #1 `CHK(master_clock_io_oe, k[0] & k[1])
            `CHK(master_clock_io_o, rnd[0])
            `CHK(core_clk_level, k[0] ? rnd[0] : ~rnd[0])
        end
        `CHK(exp_q.size(), 0)
        wrap_up();
    end
endmodule
